// File: design/cpb_pkg.sv
package cpb_pkg;

    // ------------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CPB_PH_ONE   = 2'b00,
        CPB_PH_TWO   = 2'b01,
        CPB_PH_THREE = 2'b10,
        CPB_PH_FOUR  = 2'b11
    } cpb_phase_t;

    localparam cpb_phase_t CPB_PHASE_RESET = CPB_PH_ONE;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CPB_PC_W       = 11;
    localparam int unsigned CPB_INSN_W     = 14;
    localparam int unsigned CPB_ADDR_W     = 7;
    localparam int unsigned CPB_DATA_W     = 8;
    localparam int unsigned CPB_STACK_D    = 8;
    localparam int unsigned CPB_STACK_PW   = 3;
    localparam logic [10:0] CPB_PC_RESET   = 11'h000;
    localparam logic [13:0] CPB_NOP_INSN   = 14'h0000;

    // ------------------------------------------------------------------
    // Data memory map
    // ------------------------------------------------------------------
    localparam int unsigned CPB_STATUS_BANK_BIT = 5;
    localparam logic [6:0]  CPB_SFR_LIMIT       = 7'h20;
    localparam logic [6:0]  CPB_COMMON_LO       = 7'h70;
    localparam logic [7:0]  CPB_B1_GPR_HI       = 8'hBF;
    localparam int unsigned CPB_RAM_WORDS       = 128;

    // Register file size per variant.
    localparam int unsigned CPB_GPR_SIZE_80  = 80;
    localparam int unsigned CPB_GPR_SIZE_96  = 96;
    localparam int unsigned CPB_GPR_SIZE_128 = 128;

endpackage : cpb_pkg

// File: design/cpb_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none

module cpb_phase_gen (
    input  wire logic              clk,
    input  wire logic              reset,
    output cpb_pkg::cpb_phase_t    phase,
    output logic                   phase_one,
    output logic                   phase_two,
    output logic                   phase_three,
    output logic                   phase_four
);

    cpb_pkg::cpb_phase_t next_phase;

    assign next_phase  = cpb_pkg::cpb_phase_t'(phase + 2'h1);
    assign phase_one   = (phase == cpb_pkg::CPB_PH_ONE);
    assign phase_two   = (phase == cpb_pkg::CPB_PH_TWO);
    assign phase_three = (phase == cpb_pkg::CPB_PH_THREE);
    assign phase_four  = (phase == cpb_pkg::CPB_PH_FOUR);

    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= cpb_pkg::CPB_PHASE_RESET;
        end else begin
            phase <= next_phase;
        end
    end

endmodule : cpb_phase_gen

`default_nettype wire

// File: design/cpb_core.sv
`timescale 1ns/1ps
`default_nettype none

module cpb_core #(
    parameter int unsigned GPR_SIZE = cpb_pkg::CPB_GPR_SIZE_128
) (
    input  wire logic        clk,
    input  wire logic        reset,
    // Program memory.
    output logic [10:0]      prog_addr,
    input  wire logic [13:0] prog_data,
    // Instruction presented to the execute unit.
    output logic [13:0]      instruction_latch,
    output logic             insn_valid,
    output logic [1:0]       phase,
    output logic             phase_one,
    output logic             phase_two,
    output logic             phase_three,
    output logic             phase_four,
    // Control from the execute unit.
    input  wire logic        jump_instruction,
    input  wire logic [10:0] jump_target,
    input  wire logic        call_push,
    input  wire logic        return_pop,
    // Data memory access.
    input  wire logic        use_indirect,
    input  wire logic [6:0]  direct_addr,
    input  wire logic [7:0]  indirect_pointer_reg,
    input  wire logic [7:0]  status_reg,
    input  wire logic        data_write,
    input  wire logic [7:0]  data_wdata,
    output logic [7:0]       operand,
    output logic             sfr_select,
    output logic [7:0]       sfr_addr,
    output logic             stack_overflow
);

    // ----------------------------------------------------------------
    // Phase generation
    // ----------------------------------------------------------------
    cpb_pkg::cpb_phase_t ph;

    cpb_phase_gen u_phase (
        .clk         (clk),
        .reset       (reset),
        .phase       (ph),
        .phase_one   (phase_one),
        .phase_two   (phase_two),
        .phase_three (phase_three),
        .phase_four  (phase_four)
    );

    assign phase = ph;

    // ----------------------------------------------------------------
    // Fetch pipeline
    // ----------------------------------------------------------------
    logic [10:0] program_counter;
    logic [13:0] fetch_word;
    logic        flush;
    logic [2:0]  stack_ptr;
    logic [3:0]  stack_count;
    logic [10:0] stack_mem [cpb_pkg::CPB_STACK_D];
    logic [10:0] next_pc;
    logic        redirect;

    // A redirect in this execution cycle makes the next fetched word stale.
    assign redirect  = jump_instruction | call_push | return_pop;
    assign next_pc   = return_pop
                     ? stack_mem[3'(stack_ptr - 3'h1)]
                     : (jump_instruction | call_push)
                     ? jump_target
                     : 11'(program_counter + 11'h001);
    assign prog_addr = program_counter;

    always_ff @(posedge clk) begin
        if (reset) begin
            program_counter <= cpb_pkg::CPB_PC_RESET;
        end else if (phase_one) begin
            program_counter <= 11'(program_counter + 11'h001);
        end else if (phase_four && redirect) begin
            program_counter <= next_pc;
        end
    end

    // Fetch word captured in phase four, handed to execute in phase one.
    always_ff @(posedge clk) begin
        if (reset) begin
            fetch_word <= cpb_pkg::CPB_NOP_INSN;
        end else if (phase_four) begin
            fetch_word <= prog_data;
        end
    end

    // The sequential word already fetched during a redirect is dropped.
    always_ff @(posedge clk) begin
        if (reset) begin
            flush <= 1'b1;
        end else if (phase_four) begin
            flush <= redirect;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            instruction_latch <= cpb_pkg::CPB_NOP_INSN;
            insn_valid        <= 1'b0;
        end else if (phase_one) begin
            instruction_latch <= flush ? cpb_pkg::CPB_NOP_INSN
                                       : fetch_word;
            insn_valid        <= ~flush;
        end
    end

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    // A ninth push overwrites the oldest entry; the sticky flag tells the
    // execute unit that a return address has been lost.
    logic stack_full;

    assign stack_full = (stack_count == 4'(cpb_pkg::CPB_STACK_D));

    always_ff @(posedge clk) begin
        if (reset) begin
            stack_ptr      <= 3'h0;
            stack_count    <= 4'h0;
            stack_overflow <= 1'b0;
        end else if (phase_four && call_push) begin
            stack_mem[stack_ptr] <= program_counter;
            stack_ptr            <= 3'(stack_ptr + 3'h1);
            if (stack_full) begin
                stack_overflow <= 1'b1;
            end else begin
                stack_count <= 4'(stack_count + 4'h1);
            end
        end else if (phase_four && return_pop) begin
            stack_ptr   <= 3'(stack_ptr - 3'h1);
            stack_count <= (stack_count == 4'h0) ? 4'h0
                         : 4'(stack_count - 4'h1);
        end
    end

    // ----------------------------------------------------------------
    // Data memory decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] cpb_full_addr(
        input logic       ind,
        input logic [6:0] dir,
        input logic [7:0] ptr,
        input logic [7:0] st
    );
        cpb_full_addr = ind ? ptr
                      : {st[cpb_pkg::CPB_STATUS_BANK_BIT], dir};
    endfunction : cpb_full_addr

    logic [7:0] full_addr;
    logic       bank;
    logic [6:0] offs;
    logic       is_sfr;
    logic       is_common;
    logic       ram_hit;
    logic [6:0] ram_index;
    logic [7:0] ram [cpb_pkg::CPB_RAM_WORDS];

    assign full_addr = cpb_full_addr(use_indirect, direct_addr,
                                     indirect_pointer_reg, status_reg);
    assign bank      = full_addr[7];
    assign offs      = full_addr[6:0];
    assign is_sfr    = (offs < cpb_pkg::CPB_SFR_LIMIT);
    assign is_common = bank && (offs >= cpb_pkg::CPB_COMMON_LO)
                     && (GPR_SIZE != cpb_pkg::CPB_GPR_SIZE_80);

    // Bank 0 RAM sits at index offs (20h-7Fh). Bank 1 A0h-BFh takes the
    // indices 00h-1Fh, which bank 0 never uses because its SFRs sit there,
    // so the two banks share no byte outside the common window.
    assign ram_index = (bank && !is_common)
                     ? 7'(offs - cpb_pkg::CPB_SFR_LIMIT)
                     : offs;
    assign ram_hit   = !is_sfr && (!bank
                     ? (32'(offs) < 32'(GPR_SIZE) + 32'h20
                        || GPR_SIZE == cpb_pkg::CPB_GPR_SIZE_128)
                     : (is_common
                        || (GPR_SIZE == cpb_pkg::CPB_GPR_SIZE_128
                            && full_addr <= cpb_pkg::CPB_B1_GPR_HI)));
    assign sfr_select = is_sfr;
    assign sfr_addr   = full_addr;

    always_ff @(posedge clk) begin
        if (reset) begin
            operand <= 8'h00;
        end else if (phase_two) begin
            operand <= ram_hit ? ram[ram_index] : 8'h00;
        end
    end

    // A flushed slot must not write, or a discarded instruction would
    // still change memory.
    logic ram_write;

    assign ram_write = phase_four && data_write && ram_hit && insn_valid;

    always_ff @(posedge clk) begin
        if (ram_write) begin
            ram[ram_index] <= data_wdata;
        end
    end

endmodule : cpb_core

`default_nettype wire

// File: sim/cpb_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpb_core_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [10:0] prog_addr,
    input wire logic [13:0] prog_data,
    input wire logic [13:0] instruction_latch,
    input wire logic        insn_valid,
    input wire logic [1:0]  phase,
    input wire logic        phase_one,
    input wire logic        phase_two,
    input wire logic        phase_three,
    input wire logic        phase_four,
    input wire logic        jump_instruction,
    input wire logic [10:0] jump_target,
    input wire logic        call_push,
    input wire logic        return_pop,
    input wire logic        use_indirect,
    input wire logic [6:0]  direct_addr,
    input wire logic [7:0]  indirect_pointer_reg,
    input wire logic [7:0]  status_reg,
    input wire logic [7:0]  operand,
    input wire logic [7:0]  sfr_addr
);
    // ----------------
    // Pipeline checks
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Any of the three redirects makes the prefetched word stale.
    logic redirect;
    assign redirect = jump_instruction || call_push || return_pop;
    sequence s_rest; phase_two ##1 phase_three ##1 phase_four; endsequence
    sequence s_fetch; (phase_four && !redirect) ##1 phase_one; endsequence
    sequence s_flush; (phase_four && redirect) ##1 phase_one; endsequence
    a_phase_hot: assert property (
        {phase_four, phase_three, phase_two, phase_one} == 4'h1 << phase)
        else $error("phase strobes disagree with phase");
    a_phase_order: assert property (
        phase_one |=> s_rest ##1 phase_one)
        else $error("phases out of order");
    a_pc_step: assert property (
        phase_one |=> prog_addr == $past(prog_addr) + 11'h001)
        else $error("program counter did not step in phase one");
    a_latch_hold: assert property (
        !phase_one |=> $stable(instruction_latch))
        else $error("instruction latch moved outside phase one");
    a_fetch_word: assert property (
        s_fetch |=> insn_valid && instruction_latch == $past(prog_data, 2))
        else $error("fetched word not latched");
    a_flush_slot: assert property (
        s_flush |=> !insn_valid && instruction_latch == cpb_pkg::CPB_NOP_INSN)
        else $error("prefetched word not discarded");
    a_jump_pc: assert property (
        (phase_four && jump_instruction) |=> prog_addr == $past(jump_target))
        else $error("jump target not loaded");
    a_call_pc: assert property (
        (phase_four && call_push && !return_pop)
        |=> prog_addr == $past(jump_target))
        else $error("call target not loaded");
    a_operand_hold: assert property (
        !phase_two |=> $stable(operand))
        else $error("operand moved outside phase two");
    a_bank_route: assert property (sfr_addr == (use_indirect ?
        indirect_pointer_reg : {status_reg[5], direct_addr}))
        else $error("data address routed wrongly");
endmodule : cpb_core_checker
`default_nettype wire

// File: sim/core_phase_bank_memory_tb.sv
`timescale 1ns/1ps
`default_nettype none
module core_phase_bank_memory_tb;
    logic        clk, insn_valid, sfr_select, stack_overflow, reset = 1'b1;
    logic        phase_one, phase_two, phase_three, phase_four;
    logic        call_push = 1'b0, return_pop = 1'b0, jump_instruction = 1'b0;
    logic        use_indirect = 1'b0, data_write = 1'b0;
    logic [1:0]  phase;
    logic [6:0]  direct_addr = 7'h00;
    logic [7:0]  indirect_pointer_reg = 8'h00, status_reg = 8'h00;
    logic [7:0]  data_wdata = 8'h00, operand, sfr_addr;
    logic [10:0] prog_addr, jump_target = 11'h000;
    logic [13:0] prog_data = 14'h0000, instruction_latch;
    int          errors, checked;

    cpb_core dut_u (.clk, .reset, .prog_addr, .prog_data,
        .instruction_latch, .insn_valid, .phase, .phase_one, .phase_two,
        .phase_three, .phase_four, .jump_instruction, .jump_target,
        .call_push, .return_pop, .use_indirect, .direct_addr,
        .indirect_pointer_reg, .status_reg, .data_write, .data_wdata,
        .operand, .sfr_select, .sfr_addr, .stack_overflow);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Each program word carries its own address, so a stale fetch shows.
    always @(negedge clk) prog_data <= {3'h5, prog_addr};

    // ----------------
    // Helpers
    // ----------------
    task chk(input logic [13:0] got, input logic [13:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task end_of_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task at_phase(input logic [1:0] p);
        repeat (8) begin
            @(negedge clk);
            if (phase === p) return;
        end
        errors++;
        end_of_test();
    endtask : at_phase

    // One instruction cycle of data access; direct and bank inputs are
    // scrambled on indirect access to prove that the pointer alone decides.
    task op(input logic ind, input logic [7:0] a, input logic we,
            input logic [7:0] wd);
        at_phase(2'h0);
        use_indirect = ind;
        indirect_pointer_reg = a;
        direct_addr = ind ? ~a[6:0] : a[6:0];
        status_reg = {2'h0, a[7] ^ ind, 5'h00};
        data_write = we;
        data_wdata = wd;
        at_phase(2'h0);
        data_write = 1'b0;
    endtask : op

    // ----------------
    // Scenarios
    // ----------------
    task t_pipe;
        at_phase(2'h0);
        at_phase(2'h1);
        chk(instruction_latch, {3'h5, 11'h001});
        chk(prog_addr, 11'h002);
        at_phase(2'h1);
        chk(instruction_latch, {3'h5, 11'h002});
    endtask : t_pipe

    task t_jump(input logic [10:0] tgt);
        at_phase(2'h3);
        jump_instruction = 1'b1;
        jump_target = tgt;
        at_phase(2'h0);
        jump_instruction = 1'b0;
        at_phase(2'h1);
        chk(insn_valid, 1'b0);
        chk(prog_addr, 11'(tgt + 11'h001));
        at_phase(2'h1);
        chk(instruction_latch, {3'h5, tgt + 11'h001});
    endtask : t_jump

    // The jump to 040h leaves 042h in the counter when the call is taken.
    task t_call(input logic [10:0] tgt);
        t_jump(11'h040);
        at_phase(2'h3);
        call_push = 1'b1;
        jump_target = tgt;
        at_phase(2'h0);
        call_push = 1'b0;
        at_phase(2'h1);
        chk(insn_valid, 1'b0);
        chk(prog_addr, 11'(tgt + 11'h001));
        at_phase(2'h3);
        return_pop = 1'b1;
        at_phase(2'h0);
        return_pop = 1'b0;
        at_phase(2'h1);
        chk(insn_valid, 1'b0);
        chk(prog_addr, 11'h043);
        at_phase(2'h3);
        call_push = 1'b1;
        repeat (8) at_phase(2'h3);
        chk(stack_overflow, 1'b0);
        at_phase(2'h0);
        call_push = 1'b0;
        chk(stack_overflow, 1'b1);
    endtask : t_call

    task t_mem;
        op(1'b0, 8'h20, 1'b1, 8'h11);
        op(1'b0, 8'hA0, 1'b1, 8'h3C);
        op(1'b0, 8'h70, 1'b1, 8'hA5);
        op(1'b0, 8'h60, 1'b1, 8'h5A);
        op(1'b0, 8'h05, 1'b1, 8'h77);
        chk(sfr_select, 1'b1);
        op(1'b0, 8'h05, 1'b0, 8'h00);
        chk(operand, 8'h00);
        op(1'b0, 8'h20, 1'b1, 8'h22);
        chk(operand, 8'h11);
        op(1'b0, 8'h20, 1'b0, 8'h00);
        chk(operand, 8'h22);
        op(1'b1, 8'hA0, 1'b0, 8'h00);
        chk(operand, 8'h3C);
        chk(sfr_select, 1'b0);
        op(1'b0, 8'h60, 1'b0, 8'h00);
        chk(operand, 8'h5A);
        op(1'b1, 8'hF0, 1'b0, 8'h00);
        chk(operand, 8'hA5);
    endtask : t_mem

    task t_reset;
        at_phase(2'h2);
        reset = 1'b1;
        @(negedge clk);
        chk(phase, 2'h0);
        chk(prog_addr, 11'h000);
        chk(stack_overflow, 1'b0);
        reset = 1'b0;
        t_pipe();
    endtask : t_reset

    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        t_pipe();
        t_mem();
        t_jump(11'h123);
        t_jump(11'h7FF);
        t_call(11'h200);
        t_reset();
        end_of_test();
    end
endmodule : core_phase_bank_memory_tb

bind cpb_core cpb_core_checker chk_u (.clk, .reset, .prog_addr, .prog_data,
    .instruction_latch, .insn_valid, .phase, .phase_one, .phase_two,
    .phase_three, .phase_four, .jump_instruction, .jump_target,
    .call_push, .return_pop,
    .use_indirect, .direct_addr, .indirect_pointer_reg, .status_reg,
    .operand, .sfr_addr);
`default_nettype wire
